// *** fbsl_pkg.sv ***
// Package for the fieldbus status lamp and loss response block.
// Assumes a single 250 MHz clock domain; shared by the top and the lamp pattern generator.
package fbsl_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLOCK_MHZ       = 250;
  localparam int unsigned TICK_US         = 50000;
  localparam int unsigned TICK_CYCLES     = TICK_US * CLOCK_MHZ;
  localparam int unsigned FLICKER_US      = 50000;
  localparam int unsigned FLICKER_CYCLES  = FLICKER_US * CLOCK_MHZ;
  localparam int unsigned PHASE_COUNT     = 24;
  localparam int unsigned PHASE_W         = 5;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W          = 4;
  localparam int unsigned DATA_W          = 32;
  localparam logic [ADDR_W-1:0] OFS_CONFIG   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FALLBACK = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT   = 4'h5;

  localparam int unsigned CFG_RESP_LSB    = 0;
  localparam int unsigned CFG_STOP_LSB    = 4;
  localparam int unsigned CFG_SEP_BIT     = 8;
  localparam int unsigned CFG_IOP_BIT     = 9;
  localparam int unsigned CMD_FWD_BIT     = 0;
  localparam int unsigned CMD_REV_BIT     = 1;
  localparam int unsigned CMD_RST_BIT     = 7;
  localparam int unsigned SPEED_W         = 16;
  localparam int unsigned IRQ_W           = 4;
  localparam int unsigned IRQ_INTERRUPT   = 0;
  localparam int unsigned IRQ_FAULT       = 1;
  localparam int unsigned IRQ_WATCHDOG    = 2;
  localparam int unsigned IRQ_STATE       = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    FBSL_RESP_FREEWHEEL,
    FBSL_RESP_RAMP,
    FBSL_RESP_FAST,
    FBSL_RESP_DC,
    FBSL_RESP_IGNORE,
    FBSL_RESP_PER_STOP,
    FBSL_RESP_FALLBACK,
    FBSL_RESP_MAINTAIN
  } fbsl_resp_e;

  typedef enum logic [1:0] {
    FBSL_STOP_FREEWHEEL,
    FBSL_STOP_RAMP,
    FBSL_STOP_FAST,
    FBSL_STOP_DC
  } fbsl_stop_e;

  typedef enum logic [1:0] {
    FBSL_ESM_INIT,
    FBSL_ESM_PREOP,
    FBSL_ESM_SAFEOP,
    FBSL_ESM_OP
  } fbsl_esm_e;

  typedef enum logic [2:0] {
    FBSL_PAT_OFF,
    FBSL_PAT_ON,
    FBSL_PAT_BLINK,
    FBSL_PAT_SINGLE,
    FBSL_PAT_DOUBLE,
    FBSL_PAT_FLICKER
  } fbsl_pat_e;

  typedef enum logic [1:0] {
    FBSL_DRV_RUN,
    FBSL_DRV_FALLBACK,
    FBSL_DRV_MAINTAIN,
    FBSL_DRV_FAULT
  } fbsl_drv_e;

  typedef struct packed {
    logic       link;
    logic       activity;
  } fbsl_port_s;

  typedef struct packed {
    logic       invalid_config;
    logic       local_error;
    logic       watchdog;
  } fbsl_err_s;

  typedef struct packed {
    logic [SPEED_W-1:0] net_ref;
    logic [SPEED_W-1:0] alt_ref;
    logic [7:0]         net_cmd;
    logic [7:0]         alt_cmd;
  } fbsl_chan_s;

  typedef struct packed {
    logic               fwd;
    logic               rev;
    logic               fault_reset;
    logic               stop_req;
    fbsl_stop_e         stop_kind;
    logic [SPEED_W-1:0] speed;
  } fbsl_drive_s;

  localparam fbsl_resp_e RESP_RESET = FBSL_RESP_FREEWHEEL;

endpackage

// *** fbsl_pattern.sv ***
// Lamp pattern generator: turns a pattern code into a lamp level.
// Assumes shared tick and flicker phase inputs from the top.
`timescale 1ns/1ns
module fbsl_pattern
  import fbsl_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_rstn,
  input  wire fbsl_pkg::fbsl_pat_e i_pattern,
  input  wire logic [PHASE_W-1:0] i_phase,
  input  wire logic               i_flicker,
  output logic                    o_lamp
);
  import fbsl_pkg::*;

  typedef struct packed {
    logic lamp;
  } fbsl_pat_state_s;

  fbsl_pat_state_s state_q;
  fbsl_pat_state_s state_d;

  // Phase 0..23 at 50 ms: blink 200 ms on/off, flashes of 200 ms in a 1.2 s frame
  always_comb begin
    state_d = state_q;
    unique case (i_pattern)
      FBSL_PAT_OFF:     state_d.lamp = 1'b0;
      FBSL_PAT_ON:      state_d.lamp = 1'b1;
      FBSL_PAT_BLINK:   state_d.lamp = i_phase[2];
      FBSL_PAT_SINGLE:  state_d.lamp = (i_phase < 5'h04);
      FBSL_PAT_DOUBLE:  state_d.lamp = (i_phase < 5'h04) || (i_phase >= 5'h08 && i_phase < 5'h0C);
      FBSL_PAT_FLICKER: state_d.lamp = i_flicker;
      default:          state_d.lamp = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_lamp = state_q.lamp;

endmodule

// *** fbsl_top.sv ***
// Fieldbus status lamps, communication loss response and command decode.
// Assumes synchronous status inputs and a single-cycle register port master.
`timescale 1ns/1ns
module fbsl_top
  import fbsl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P    = TICK_CYCLES,
  parameter int unsigned FLICKER_CYCLES_P = FLICKER_CYCLES / 10
)
(
  input  wire logic                 i_clock,
  input  wire logic                 i_rstn,
  input  wire fbsl_pkg::fbsl_port_s i_port_a,
  input  wire fbsl_pkg::fbsl_port_s i_port_b,
  input  wire fbsl_pkg::fbsl_esm_e  i_esm_state,
  input  wire fbsl_pkg::fbsl_err_s  i_errors,
  input  wire logic                 i_interrupt,
  input  wire fbsl_pkg::fbsl_chan_s i_channels,
  input  wire logic [SPEED_W-1:0]   i_actual_speed,
  input  wire logic [ADDR_W-1:0]    i_addr,
  input  wire logic [DATA_W-1:0]    i_wdata,
  input  wire logic                 i_write,
  input  wire logic                 i_read,
  output logic [DATA_W-1:0]         o_rdata,
  output logic                      o_irq,
  output logic                      o_port_a_link_lamp,
  output logic                      o_port_b_link_lamp,
  output logic                      o_run_lamp,
  output logic                      o_error_lamp,
  output fbsl_pkg::fbsl_drive_s     o_drive,
  output logic                      o_fault
);
  import fbsl_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0]        tick_cnt;
    logic [31:0]        flick_cnt;
    logic [PHASE_W-1:0] phase;
    logic               flicker;
    fbsl_resp_e         resp;
    fbsl_stop_e         stop_type;
    logic               separate;
    logic               io_profile;
    logic [SPEED_W-1:0] fallback_speed_value;
    logic [SPEED_W-1:0] held_speed;
    fbsl_drv_e          drv;
    logic               intr_q;
    logic               wd_q;
    fbsl_esm_e          esm_q;
    logic [IRQ_W-1:0]   irq_stat;
    logic [IRQ_W-1:0]   irq_mask;
    logic [DATA_W-1:0]  rdata;
    logic               irq;
    fbsl_drive_s        drive;
    logic               fault;
  } fbsl_state_s;

  fbsl_state_s state_q;
  fbsl_state_s state_d;

  fbsl_pat_e pat_a;
  fbsl_pat_e pat_b;
  fbsl_pat_e pat_run;
  fbsl_pat_e pat_err;

  logic [7:0]         cmd_word;
  logic [SPEED_W-1:0] ref_word;
  logic               run_cmd;
  logic               intr_seen;
  logic               intr_rise;
  logic [IRQ_W-1:0]   irq_event;
  logic               faulting_resp;

  // ****************************************************************
  // Lamp pattern selection
  // ****************************************************************
  function automatic fbsl_pat_e port_pattern(input fbsl_port_s p);
    if (!p.link) begin
      return FBSL_PAT_OFF;
    end
    return p.activity ? FBSL_PAT_FLICKER : FBSL_PAT_ON;
  endfunction

  always_comb begin
    pat_a = port_pattern(i_port_a);
    pat_b = port_pattern(i_port_b);
    unique case (i_esm_state)
      FBSL_ESM_INIT:   pat_run = FBSL_PAT_OFF;
      FBSL_ESM_PREOP:  pat_run = FBSL_PAT_BLINK;
      FBSL_ESM_SAFEOP: pat_run = FBSL_PAT_SINGLE;
      FBSL_ESM_OP:     pat_run = FBSL_PAT_ON;
    endcase
    if (i_errors.watchdog) begin
      pat_err = FBSL_PAT_DOUBLE;
    end else if (i_errors.local_error) begin
      pat_err = FBSL_PAT_SINGLE;
    end else if (i_errors.invalid_config) begin
      pat_err = FBSL_PAT_BLINK;
    end else begin
      pat_err = FBSL_PAT_OFF;
    end
  end

  // ****************************************************************
  // Channel selection and command decode
  // ****************************************************************
  always_comb begin
    cmd_word = i_channels.net_cmd;
    // Separate mode keeps commands on the network, only the reference moves
    ref_word = state_q.separate ? i_channels.alt_ref : i_channels.net_ref;
    run_cmd  = state_q.io_profile ? (cmd_word[CMD_FWD_BIT] | cmd_word[CMD_REV_BIT])
                                  : (ref_word != '0);
    // Ignoring the interruption means no monitoring at all
    intr_seen = i_interrupt && (state_q.resp != FBSL_RESP_IGNORE);
    intr_rise = intr_seen && !state_q.intr_q;
    faulting_resp = (state_q.resp == FBSL_RESP_FREEWHEEL) || (state_q.resp == FBSL_RESP_RAMP)
                 || (state_q.resp == FBSL_RESP_FAST) || (state_q.resp == FBSL_RESP_DC);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    // Free running pattern timebase; shared by all four lamps so they stay in step
    if (state_q.tick_cnt >= TICK_CYCLES_P - 1) begin
      state_d.tick_cnt = '0;
      state_d.phase = (state_q.phase == PHASE_W'(PHASE_COUNT - 1)) ? '0
                    : PHASE_W'(state_q.phase + 1'b1);
    end else begin
      state_d.tick_cnt = state_q.tick_cnt + 32'h1;
    end
    if (state_q.flick_cnt >= FLICKER_CYCLES_P - 1) begin
      state_d.flick_cnt = '0;
      state_d.flicker = !state_q.flicker;
    end else begin
      state_d.flick_cnt = state_q.flick_cnt + 32'h1;
    end

    state_d.intr_q = intr_seen;
    state_d.wd_q   = i_errors.watchdog;
    state_d.esm_q  = i_esm_state;

    // Response to an interruption
    unique case (state_q.drv)
      FBSL_DRV_RUN: begin
        if (intr_rise) begin
          state_d.held_speed = i_actual_speed;
          if (faulting_resp) begin
            state_d.drv = FBSL_DRV_FAULT;
          end else if (state_q.resp == FBSL_RESP_FALLBACK && run_cmd) begin
            state_d.drv = FBSL_DRV_FALLBACK;
          end else if (state_q.resp == FBSL_RESP_MAINTAIN && run_cmd) begin
            state_d.drv = FBSL_DRV_MAINTAIN;
          end
        end
      end
      FBSL_DRV_FALLBACK, FBSL_DRV_MAINTAIN: begin
        if (!intr_seen || !run_cmd) begin
          state_d.drv = FBSL_DRV_RUN;
        end
      end
      FBSL_DRV_FAULT: begin
        if (!intr_seen && state_q.io_profile && cmd_word[CMD_RST_BIT]) begin
          state_d.drv = FBSL_DRV_RUN;
        end
      end
    endcase

    state_d.fault = (state_d.drv == FBSL_DRV_FAULT);
    state_d.drive.fault_reset = state_q.io_profile && cmd_word[CMD_RST_BIT];
    state_d.drive.fwd = state_q.io_profile && cmd_word[CMD_FWD_BIT];
    state_d.drive.rev = state_q.io_profile && cmd_word[CMD_REV_BIT];
    state_d.drive.stop_req = 1'b0;
    state_d.drive.stop_kind = FBSL_STOP_FREEWHEEL;
    state_d.drive.speed = ref_word;
    unique case (state_d.drv)
      FBSL_DRV_FALLBACK: state_d.drive.speed = state_q.fallback_speed_value;
      FBSL_DRV_MAINTAIN: state_d.drive.speed = state_d.held_speed;
      FBSL_DRV_FAULT: begin
        state_d.drive.stop_req = 1'b1;
        state_d.drive.stop_kind = fbsl_stop_e'(state_q.resp[1:0]);
      end
      FBSL_DRV_RUN: begin
        if (intr_seen && state_q.resp == FBSL_RESP_PER_STOP) begin
          state_d.drive.stop_req = 1'b1;
          state_d.drive.stop_kind = state_q.stop_type;
        end
      end
    endcase

    // Interrupt status: set wins over a same-cycle clear
    irq_event = '0;
    irq_event[IRQ_INTERRUPT] = intr_rise;
    irq_event[IRQ_FAULT]     = (state_d.drv == FBSL_DRV_FAULT) && (state_q.drv != FBSL_DRV_FAULT);
    irq_event[IRQ_WATCHDOG]  = i_errors.watchdog && !state_q.wd_q;
    irq_event[IRQ_STATE]     = (i_esm_state != state_q.esm_q);

    state_d.rdata = '0;
    if (i_write) begin
      unique case (i_addr)
        OFS_CONFIG: begin
          state_d.resp       = fbsl_resp_e'(i_wdata[CFG_RESP_LSB +: 3]);
          state_d.stop_type  = fbsl_stop_e'(i_wdata[CFG_STOP_LSB +: 2]);
          state_d.separate   = i_wdata[CFG_SEP_BIT];
          state_d.io_profile = i_wdata[CFG_IOP_BIT];
        end
        OFS_FALLBACK: state_d.fallback_speed_value = i_wdata[SPEED_W-1:0];
        OFS_IRQ_STAT: state_d.irq_stat = state_q.irq_stat & ~i_wdata[IRQ_W-1:0];
        OFS_IRQ_MASK: state_d.irq_mask = i_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    state_d.irq_stat = state_d.irq_stat | irq_event;
    if (i_read) begin
      unique case (i_addr)
        OFS_CONFIG: begin
          state_d.rdata[CFG_RESP_LSB +: 3] = state_q.resp;
          state_d.rdata[CFG_STOP_LSB +: 2] = state_q.stop_type;
          state_d.rdata[CFG_SEP_BIT]       = state_q.separate;
          state_d.rdata[CFG_IOP_BIT]       = state_q.io_profile;
        end
        OFS_FALLBACK: state_d.rdata[SPEED_W-1:0] = state_q.fallback_speed_value;
        OFS_STATUS:   state_d.rdata[15:0] = {4'h0, state_q.drv, state_q.esm_q,
                                             i_errors, state_q.intr_q,
                                             i_port_a, i_port_b};
        OFS_IRQ_STAT: state_d.rdata[IRQ_W-1:0] = state_q.irq_stat;
        OFS_IRQ_MASK: state_d.rdata[IRQ_W-1:0] = state_q.irq_mask;
        OFS_OUTPUT:   state_d.rdata[SPEED_W-1:0] = state_q.drive.speed;
        default: ;
      endcase
    end
    state_d.irq = |(state_d.irq_stat & state_d.irq_mask);
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= '0;
      state_q.resp <= RESP_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Lamp drivers
  // ****************************************************************
  fbsl_pattern u_lamp_a (
    .i_clock   (i_clock),
    .i_rstn    (i_rstn),
    .i_pattern (pat_a),
    .i_phase   (state_q.phase),
    .i_flicker (state_q.flicker),
    .o_lamp    (o_port_a_link_lamp)
  );

  fbsl_pattern u_lamp_b (
    .i_clock   (i_clock),
    .i_rstn    (i_rstn),
    .i_pattern (pat_b),
    .i_phase   (state_q.phase),
    .i_flicker (state_q.flicker),
    .o_lamp    (o_port_b_link_lamp)
  );

  fbsl_pattern u_lamp_run (
    .i_clock   (i_clock),
    .i_rstn    (i_rstn),
    .i_pattern (pat_run),
    .i_phase   (state_q.phase),
    .i_flicker (state_q.flicker),
    .o_lamp    (o_run_lamp)
  );

  fbsl_pattern u_lamp_err (
    .i_clock   (i_clock),
    .i_rstn    (i_rstn),
    .i_pattern (pat_err),
    .i_phase   (state_q.phase),
    .i_flicker (state_q.flicker),
    .o_lamp    (o_error_lamp)
  );

  assign o_rdata = state_q.rdata;
  assign o_irq   = state_q.irq;
  assign o_drive = state_q.drive;
  assign o_fault = state_q.fault;

endmodule

// *** fbsl_master_model.sv ***
// Behavioural fieldbus master: drives command and reference words to the block.
// Assumes the bench sets the wanted words; outputs change only after a clock edge.
`timescale 1ns/1ns
module fbsl_master_model
  import fbsl_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_rstn,
  input  wire logic [7:0]         i_cmd,
  input  wire logic [SPEED_W-1:0] i_ref,
  input  wire logic [SPEED_W-1:0] i_alt_ref,
  input  wire logic               i_drop,
  output fbsl_pkg::fbsl_chan_s    o_channels,
  output logic                    o_interrupt
);
  import fbsl_pkg::*;

  // ********
  // Words
  // ********
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_channels  <= '0;
      o_interrupt <= 1'b0;
    end else begin
      o_channels.net_cmd <= i_cmd;
      o_channels.net_ref <= i_ref;
      o_channels.alt_ref <= i_alt_ref;
      // Unused word keeps changing so a stale value never looks valid
      o_channels.alt_cmd <= ~o_channels.alt_cmd;
      o_interrupt        <= i_drop;
    end
  end
endmodule

// *** fbsl_assertions.sv ***
// Concurrent checks on the status lamp and loss response top.
// Assumes it is bound to fbsl_top and sees only its ports.
`timescale 1ns/1ns
module fbsl_assertions
  import fbsl_pkg::*;
(
  input wire logic                 i_clock,
  input wire logic                 i_rstn,
  input wire fbsl_pkg::fbsl_port_s i_port_a,
  input wire fbsl_pkg::fbsl_port_s i_port_b,
  input wire fbsl_pkg::fbsl_esm_e  i_esm_state,
  input wire fbsl_pkg::fbsl_err_s  i_errors,
  input wire logic                 i_interrupt,
  input wire fbsl_pkg::fbsl_chan_s i_channels,
  input wire logic [ADDR_W-1:0]    i_addr,
  input wire logic [DATA_W-1:0]    i_wdata,
  input wire logic                 i_write,
  input wire logic                 i_read,
  input wire logic [DATA_W-1:0]    o_rdata,
  input wire logic                 o_port_a_link_lamp,
  input wire logic                 o_port_b_link_lamp,
  input wire logic                 o_run_lamp,
  input wire logic                 o_error_lamp,
  input wire fbsl_pkg::fbsl_drive_s o_drive,
  input wire logic                 o_fault
);
  import fbsl_pkg::*;

  // ********
  // Config shadow, tracked from bus writes
  // ********
  logic [9:0] cfg_q;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_q <= '0;
    end else if (i_write && i_addr == OFS_CONFIG) begin
      cfg_q <= i_wdata[9:0];
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence s_loss_rise;
    $rose(i_interrupt);
  endsequence
  // ********
  // Properties
  // ********
  a_rdata_config: assert property (
    i_read && i_addr == OFS_CONFIG |=> o_rdata[2:0] == cfg_q[2:0])
    else $error("config readback differs");
  a_fault_on_loss: assert property (
    s_loss_rise ##0 cfg_q[2:0] < 3'h4 |=> o_fault && o_drive.stop_req
      && o_drive.stop_kind == cfg_q[1:0]) else $error("hard loss response missed");
  a_soft_no_fault: assert property (
    s_loss_rise ##0 cfg_q[2:0] >= 3'h4 && !o_fault |=> !o_fault)
    else $error("soft response entered fault");
  a_ignore_quiet: assert property (
    s_loss_rise ##0 cfg_q[2:0] == 3'h4 && !o_drive.stop_req |=> (!o_drive.stop_req) [*3])
    else $error("ignore response stopped");
  a_per_stop_kind: assert property (
    $past(i_interrupt) && $past(cfg_q[2:0]) == 3'h5 |-> o_drive.stop_req
      && o_drive.stop_kind == $past(cfg_q[5:4])) else $error("per stop kind wrong");
  a_cmd_decode: assert property (
    $past(cfg_q[CFG_IOP_BIT]) && !o_fault && !o_drive.stop_req |->
      o_drive.fwd == $past(i_channels.net_cmd[0]) && o_drive.rev == $past(i_channels.net_cmd[1]))
    else $error("command bits misdecoded");
  a_port_a_dark: assert property (
    (!i_port_a.link) [*3] |-> !o_port_a_link_lamp) else $error("lamp lit without link");
  a_port_b_steady: assert property (
    (i_port_b.link && !i_port_b.activity) [*3] |-> o_port_b_link_lamp)
    else $error("idle link lamp not steady");
  a_run_lamp_op: assert property (
    (i_esm_state == FBSL_ESM_OP) [*3] |-> o_run_lamp) else $error("run lamp dark in op");
  a_err_lamp_off: assert property (
    (i_errors == '0) [*3] |-> !o_error_lamp) else $error("error lamp lit without error");
endmodule
bind fbsl_top fbsl_assertions u_chk (
  .i_clock, .i_rstn, .i_port_a, .i_port_b, .i_esm_state, .i_errors, .i_interrupt,
  .i_channels, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata, .o_port_a_link_lamp,
  .o_port_b_link_lamp, .o_run_lamp, .o_error_lamp, .o_drive, .o_fault);

// *** testbench.sv ***
// Self-checking bench for the status lamp and loss response top.
// Assumes a 250 MHz clock; all inputs change by NBA at rising edges.
`timescale 1ns/1ns
module testbench;
  import fbsl_pkg::*;
  localparam int TICK  = 4;
  localparam int FRAME = PHASE_COUNT * TICK;
  logic               clock  = 1'b0;
  logic               rstn   = 1'b0;
  fbsl_port_s         port_a = '0;
  fbsl_port_s         port_b = '0;
  fbsl_esm_e          esm    = FBSL_ESM_INIT;
  fbsl_err_s          errs   = '0;
  fbsl_chan_s         chans;
  fbsl_drive_s        drive;
  logic               intr, irq, fault, la, lb, lrun, lerr;
  logic               drop   = 1'b0;
  logic               wr     = 1'b0;
  logic               rd     = 1'b0;
  logic [7:0]         cmd    = 8'h01;
  logic [SPEED_W-1:0] ref_v  = 16'h0100;
  logic [SPEED_W-1:0] alt_v  = 16'h0000;
  logic [SPEED_W-1:0] act    = 16'h0000;
  logic [ADDR_W-1:0]  addr   = 4'h0;
  logic [DATA_W-1:0]  wdata  = 32'h0;
  logic [DATA_W-1:0]  rdata, got;
  logic [3:0]         lamps;
  int                 n_errors  = 0;
  int                 tests_run = 0;
  // Lamp duty over one frame; single and double differ in count, blink and flicker both give half
  int                 pexp[3] = '{0, FRAME, FRAME / 2};
  int                 rexp[4] = '{0, FRAME / 2, FRAME / 6, FRAME};
  logic [2:0]         eset[6] = '{3'h0, 3'h4, 3'h1, 3'h2, 3'h7, 3'h6};
  int                 eexp[6] = '{0, FRAME / 2, FRAME / 3, FRAME / 6, FRAME / 3, FRAME / 6};
  assign lamps = {la, lb, lrun, lerr};
  always #2 clock = ~clock;

  fbsl_master_model master (
    .i_clock(clock), .i_rstn(rstn), .i_cmd(cmd), .i_ref(ref_v),
    .i_alt_ref(alt_v), .i_drop(drop), .o_channels(chans), .o_interrupt(intr));
  fbsl_top #(.TICK_CYCLES_P(TICK), .FLICKER_CYCLES_P(2)) dut (
    .i_clock(clock), .i_rstn(rstn), .i_port_a(port_a), .i_port_b(port_b),
    .i_esm_state(esm), .i_errors(errs), .i_interrupt(intr), .i_channels(chans),
    .i_actual_speed(act), .i_addr(addr), .i_wdata(wdata), .i_write(wr),
    .i_read(rd), .o_rdata(rdata), .o_irq(irq), .o_port_a_link_lamp(la),
    .o_port_b_link_lamp(lb), .o_run_lamp(lrun), .o_error_lamp(lerr),
    .o_drive(drive), .o_fault(fault));

  // ********
  // Tasks
  // ********
  task automatic end_sim;
    $display("Checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe edge
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic set_drop(input logic v);
    @(posedge clock);
    drop <= v;
    cyc(3);
  endtask
  task automatic lamp_cnt(input int sel, input int exp);
    int n;
    n = 0;
    cyc(3);
    repeat (FRAME) begin
      cyc(1);
      n += int'(lamps[sel]);
    end
    chk(n, exp);
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    #200000;
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd_reg(OFS_CONFIG, got);
    chk(got, 32'h0);
    rd_reg(4'hF, got);
    chk(got, 32'h0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      port_a <= {i > 0, i > 1};
      port_b <= {i > 0, i > 1};
      lamp_cnt(3, pexp[i]);
      lamp_cnt(2, pexp[i]);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      esm <= fbsl_esm_e'(i);
      lamp_cnt(1, rexp[i]);
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      errs <= eset[i];
      lamp_cnt(0, eexp[i]);
    end
    @(posedge clock);
    errs <= '0;
    for (int r = 0; r < 4; r++) begin
      wr_reg(OFS_CONFIG, 32'h200 | r);
      set_drop(1'b1);
      chk(fault, 1'b1);
      chk(drive.stop_req, 1'b1);
      chk(drive.stop_kind, r);
      @(posedge clock);
      cmd <= 8'h80;
      set_drop(1'b0);
      chk(fault, 1'b0);
      chk(drive.fault_reset, 1'b1);
      @(posedge clock);
      cmd <= 8'h01;
    end
    // Step off the launching edge before sampling a registered output
    cyc(1);
    chk(irq, 1'b0);
    wr_reg(OFS_IRQ_MASK, 32'h2);
    cyc(2);
    chk(irq, 1'b1);
    wr_reg(OFS_IRQ_STAT, 32'hF);
    cyc(2);
    chk(irq, 1'b0);
    rd_reg(OFS_IRQ_STAT, got);
    chk(got, 32'h0);
    wr_reg(OFS_CONFIG, 32'h204);
    set_drop(1'b1);
    chk(fault, 1'b0);
    chk(drive.stop_req, 1'b0);
    chk(drive.speed, 32'h100);
    set_drop(1'b0);
    wr_reg(OFS_CONFIG, 32'h225);
    set_drop(1'b1);
    chk(drive.stop_req, 1'b1);
    chk(drive.stop_kind, 32'h2);
    wr_reg(OFS_CONFIG, 32'h235);
    cyc(2);
    chk(drive.stop_kind, 32'h3);
    chk(fault, 1'b0);
    set_drop(1'b0);
    wr_reg(OFS_FALLBACK, 32'h1234);
    wr_reg(OFS_CONFIG, 32'h206);
    set_drop(1'b1);
    chk(drive.speed, 32'h1234);
    rd_reg(OFS_OUTPUT, got);
    chk(got, 32'h1234);
    set_drop(1'b0);
    chk(drive.speed, 32'h100);
    @(posedge clock);
    act <= 16'h0ABC;
    wr_reg(OFS_CONFIG, 32'h207);
    set_drop(1'b1);
    @(posedge clock);
    act <= 16'h0DEF;
    cyc(3);
    chk(drive.speed, 32'hABC);
    chk(fault, 1'b0);
    set_drop(1'b0);
    chk(drive.speed, 32'h100);
    @(posedge clock);
    cmd <= 8'h02;
    cyc(3);
    chk({drive.fwd, drive.rev}, 2'h1);
    @(posedge clock);
    alt_v <= 16'h0777;
    cmd   <= 8'h01;
    wr_reg(OFS_CONFIG, 32'h300);
    cyc(3);
    chk(drive.speed, 32'h777);
    chk({drive.fwd, drive.rev}, 2'h2);
    // Mid-run reset must bring the response back to freewheel
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd_reg(OFS_CONFIG, got);
    chk(got, 32'h0);
    rd_reg(OFS_STATUS, got);
    chk(got, 32'h30F);
    end_sim;
  end
endmodule
